/* dsle_pkg.sv */
// Constants and types for the drive drive_state_indicator encoder.
// Assumes a 50 MHz system clock; all timing derives from it.
package dsle_pkg;

	localparam int CLK_HZ = 50_000_000;
	// Blink slot length in milliseconds
	localparam int SLOT_MS = 200;
	localparam int SLOT_CYCLES = CLK_HZ / 1000 * SLOT_MS;
	localparam int TB_W = 24;
	localparam int SLOT_W = 4;
	localparam logic [SLOT_W-1:0] SLOT_LAST = 4'h9;
	localparam logic [SLOT_W-1:0] SINGLE_SLOT = 4'h0;
	localparam logic [SLOT_W-1:0] DOUBLE_SLOT = 4'h2;
	localparam int CODE_W = 4;
	localparam logic [CODE_W-1:0] CODE_PAUSE_LAST = 4'h4;
	localparam logic [CODE_W-1:0] CODE_MIN = 4'h1;

	// Network state machine, one-hot on the input port
	localparam logic [3:0] NET_INIT = 4'h1;
	localparam logic [3:0] NET_PREOP = 4'h2;
	localparam logic [3:0] NET_SAFEOP = 4'h4;
	localparam logic [3:0] NET_OP = 4'h8;

	typedef enum logic [4:0] {
		ST_OFF = 5'h01,
		ST_WAIT = 5'h02,
		ST_ON = 5'h04,
		ST_FAULT = 5'h08,
		ST_BOOT = 5'h10
	} dsle_stat_t;

	typedef enum logic [3:0] {
		ER_NONE = 4'h1,
		ER_CFG = 4'h2,
		ER_LOCAL = 4'h4,
		ER_WDOG = 4'h8
	} dsle_err_t;

	typedef enum logic [2:0] {
		CS_ON = 3'h1,
		CS_GAP = 3'h2,
		CS_PAUSE = 3'h4
	} dsle_code_st_t;

	typedef struct packed {
		logic [TB_W-1:0] cnt;
		logic [SLOT_W-1:0] slot;
		logic tick;
		logic flash;
		logic single;
		logic dbl;
	} dsle_tb_t;

	typedef struct packed {
		dsle_code_st_t st;
		logic [CODE_W-1:0] cnt;
		logic on;
	} dsle_code_t;

	typedef struct packed {
		dsle_stat_t st;
		dsle_err_t err;
		logic state_green;
		logic state_red;
		logic stage_off;
		logic supply_green;
		logic run_green;
		logic fault_red;
		logic link_green;
	} dsle_top_t;

endpackage

/* dsle_timebase.sv */
// Shared blink timebase: slot tick plus flash, single and double patterns.
// Assumes synchronous reset; patterns repeat every ten slots.
`timescale 1ns/1ps
module dsle_timebase import dsle_pkg::*; #(
	parameter int TICK_CYCLES = SLOT_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_srst,
	output logic o_tick,
	output logic o_flash,
	output logic o_single,
	output logic o_double
);
	dsle_tb_t tb_reg;
	dsle_tb_t tb_next;

	always_comb begin
		tb_next = tb_reg;
		tb_next.tick = 1'b0;
		if (tb_reg.cnt == TB_W'(TICK_CYCLES - 1)) begin
			tb_next.cnt = '0;
			tb_next.tick = 1'b1;
			if (tb_reg.slot == SLOT_LAST) begin
				tb_next.slot = '0;
			end else begin
				tb_next.slot = tb_reg.slot + SLOT_W'(1);
			end
		end else begin
			tb_next.cnt = tb_reg.cnt + TB_W'(1);
		end
		tb_next.flash = ~tb_next.slot[0];
		tb_next.single = tb_next.slot == SINGLE_SLOT;
		tb_next.dbl = tb_next.single | (tb_next.slot == DOUBLE_SLOT);
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			// Slot 0 lights every pattern, so reset matches it
			tb_reg <= '{flash: 1'b1, single: 1'b1, dbl: 1'b1, default: '0};
		end else begin
			tb_reg <= tb_next;
		end
	end

	assign o_tick = tb_reg.tick;
	assign o_flash = tb_reg.flash;
	assign o_single = tb_reg.single;
	assign o_double = tb_reg.dbl;
endmodule

/* dsle_code_blinker.sv */
// Error-code blinker: N pulses of one slot each, then a pause.
// Assumes i_tick is a one-cycle pulse per blink slot.
`timescale 1ns/1ps
module dsle_code_blinker import dsle_pkg::*; (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_tick,
	input wire logic i_enable,
	input wire logic [CODE_W-1:0] i_code,
	output logic o_on
);
	dsle_code_t cb_reg;
	dsle_code_t cb_next;
	logic [CODE_W-1:0] code_eff;

	always_comb begin
		cb_next = cb_reg;
		// Code zero would never blink, so it shows as one pulse
		code_eff = (i_code < CODE_MIN) ? CODE_MIN : i_code;
		if (!i_enable) begin
			cb_next.st = CS_PAUSE;
			cb_next.cnt = '0;
			cb_next.on = 1'b0;
		end else if (i_tick) begin
			case (cb_reg.st)
				CS_ON: begin
					cb_next.on = 1'b0;
					// Last pulse goes straight to the pause, no extra gap
					if (cb_reg.cnt + CODE_W'(1) >= code_eff) begin
						cb_next.st = CS_PAUSE;
						cb_next.cnt = '0;
					end else begin
						cb_next.st = CS_GAP;
					end
				end
				CS_GAP: begin
					cb_next.st = CS_ON;
					cb_next.cnt = cb_reg.cnt + CODE_W'(1);
					cb_next.on = 1'b1;
				end
				CS_PAUSE: begin
					if (cb_reg.cnt == CODE_PAUSE_LAST) begin
						cb_next.st = CS_ON;
						cb_next.cnt = '0;
						cb_next.on = 1'b1;
					end else begin
						cb_next.cnt = cb_reg.cnt + CODE_W'(1);
					end
				end
				default: begin
					cb_next.st = CS_PAUSE;
					cb_next.cnt = '0;
					cb_next.on = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cb_reg <= '{st: CS_PAUSE, cnt: '0, on: 1'b0};
		end else begin
			cb_reg <= cb_next;
		end
	end

	assign o_on = cb_reg.on;
endmodule

/* dsle_led_encoder.sv */
// Drive drive_state_indicator encoder: maps drive, supply and network state to LEDs.
// Assumes all inputs are synchronous levels on i_clk.
`timescale 1ns/1ps
module dsle_led_encoder import dsle_pkg::*; #(
	parameter int TICK_CYCLES = SLOT_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_fieldbus_variant,
	input wire logic i_drive_active,
	input wire logic i_op_enabled,
	input wire logic i_fault,
	input wire logic i_boot_fail,
	input wire logic [CODE_W-1:0] i_boot_code,
	input wire logic i_supply_ok,
	input wire logic [3:0] i_net_state,
	input wire logic i_net_connected,
	input wire logic i_cfg_defect,
	input wire logic i_local_err,
	input wire logic i_wdog_timeout,
	input wire logic i_link_up,
	input wire logic i_link_traffic,
	output logic o_drive_state_indicator_green,
	output logic o_drive_state_indicator_red,
	output logic o_stage_off,
	output logic o_supply_ok_indicator,
	output logic o_network_run_indicator,
	output logic o_network_fault_indicator,
	output logic o_link_activity_indicator
);
	dsle_top_t top_reg;
	dsle_top_t top_next;
	logic tb_tick;
	logic tb_flash;
	logic tb_single;
	logic tb_double;
	logic code_on;

	dsle_timebase #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timebase (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.o_tick(tb_tick),
		.o_flash(tb_flash),
		.o_single(tb_single),
		.o_double(tb_double)
	);

	dsle_code_blinker u_code (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_tick(tb_tick),
		.i_enable(i_boot_fail),
		.i_code(i_boot_code),
		.o_on(code_on)
	);

	always_comb begin
		top_next = top_reg;
		// Boot failure outranks a fault: the drive never came up
		if (i_boot_fail) begin
			top_next.st = ST_BOOT;
		end else if (i_fault) begin
			top_next.st = ST_FAULT;
		end else if (i_drive_active && i_op_enabled) begin
			top_next.st = ST_ON;
		end else if (i_drive_active) begin
			top_next.st = ST_WAIT;
		end else begin
			top_next.st = ST_OFF;
		end
		top_next.state_green = 1'b0;
		top_next.state_red = 1'b0;
		case (top_next.st)
			ST_BOOT: top_next.state_red = code_on;
			ST_FAULT: top_next.state_red = tb_flash;
			ST_ON: top_next.state_green = 1'b1;
			ST_WAIT: top_next.state_green = tb_flash;
			default: begin
				top_next.state_green = 1'b0;
				top_next.state_red = 1'b0;
			end
		endcase
		// Held off on fault even if the drive still reports active
		top_next.stage_off = i_fault | i_boot_fail;
		top_next.supply_green = i_supply_ok;

		// Network_run_indicator; serial variant has no such LED, kept dark
		top_next.run_green = 1'b0;
		if (i_fieldbus_variant) begin
			case (i_net_state)
				NET_OP: top_next.run_green = i_net_connected;
				NET_PREOP: top_next.run_green = tb_flash;
				NET_SAFEOP: top_next.run_green = tb_single;
				NET_INIT: top_next.run_green = 1'b0;
				default: top_next.run_green = 1'b0;
			endcase
		end

		if (!i_fieldbus_variant) begin
			top_next.err = ER_NONE;
		end else if (i_wdog_timeout) begin
			top_next.err = ER_WDOG;
		end else if (i_local_err) begin
			top_next.err = ER_LOCAL;
		end else if (i_cfg_defect) begin
			top_next.err = ER_CFG;
		end else begin
			top_next.err = ER_NONE;
		end
		case (top_next.err)
			ER_WDOG: top_next.fault_red = tb_double;
			ER_LOCAL: top_next.fault_red = tb_single;
			ER_CFG: top_next.fault_red = tb_flash;
			ER_NONE: top_next.fault_red = 1'b0;
			default: top_next.fault_red = 1'b0;
		endcase

		if (!i_link_up) begin
			top_next.link_green = 1'b0;
		end else if (i_link_traffic) begin
			top_next.link_green = tb_flash;
		end else begin
			top_next.link_green = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			top_reg <= '{st: ST_OFF, err: ER_NONE, default: 1'b0};
		end else begin
			top_reg <= top_next;
		end
	end

	assign o_drive_state_indicator_green = top_reg.state_green;
	assign o_drive_state_indicator_red = top_reg.state_red;
	assign o_stage_off = top_reg.stage_off;
	assign o_supply_ok_indicator = top_reg.supply_green;
	assign o_network_run_indicator = top_reg.run_green;
	assign o_network_fault_indicator = top_reg.fault_red;
	assign o_link_activity_indicator = top_reg.link_green;

	default clocking dsle_cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);

	drive_enabled_a: assert property (
		i_drive_active && i_op_enabled && !i_fault && !i_boot_fail
		|=> o_drive_state_indicator_green && !o_drive_state_indicator_red)
		else $error("status not steady green when enabled");

	drive_wait_a: assert property (
		i_drive_active && !i_op_enabled && !i_fault && !i_boot_fail
		|=> o_drive_state_indicator_green == $past(tb_flash))
		else $error("status not flashing green while waiting");

	drive_fault_a: assert property (
		i_fault && !i_boot_fail
		|=> o_drive_state_indicator_red == $past(tb_flash)
		&& !o_drive_state_indicator_green && o_stage_off)
		else $error("fault pattern or stage off wrong");

	boot_code_a: assert property (
		i_boot_fail |=> o_drive_state_indicator_red == $past(code_on)
		&& !o_drive_state_indicator_green && o_stage_off)
		else $error("boot failure pattern wrong");

	supply_led_a: assert property (
		1'b1 |=> o_supply_ok_indicator == $past(i_supply_ok))
		else $error("supply LED does not follow supply");

	run_op_a: assert property (
		i_fieldbus_variant && i_net_state == NET_OP && i_net_connected
		|=> o_network_run_indicator)
		else $error("network_run_indicator not steady when operational");

	run_preop_a: assert property (
		i_fieldbus_variant && i_net_state == NET_PREOP
		|=> o_network_run_indicator == $past(tb_flash))
		else $error("network_run_indicator not flashing in pre-operational");

	run_safeop_a: assert property (
		i_fieldbus_variant && i_net_state == NET_SAFEOP
		|=> o_network_run_indicator == $past(tb_single))
		else $error("network_run_indicator not single flash in safe-operational");

	run_init_a: assert property (
		i_net_state == NET_INIT |=> !o_network_run_indicator)
		else $error("network_run_indicator lit in initialization");

	err_cfg_a: assert property (
		i_fieldbus_variant && i_cfg_defect && !i_local_err
		&& !i_wdog_timeout
		|=> o_network_fault_indicator == $past(tb_flash))
		else $error("error LED not flashing on bad configuration");

	err_local_a: assert property (
		i_fieldbus_variant && i_local_err && !i_wdog_timeout
		|=> o_network_fault_indicator == $past(tb_single))
		else $error("error LED not single flash on local error");

	err_wdog_a: assert property (
		i_fieldbus_variant && i_wdog_timeout
		|=> o_network_fault_indicator == $past(tb_double))
		else $error("error LED not double flash on watchdog");

	err_none_a: assert property (
		!i_cfg_defect && !i_local_err && !i_wdog_timeout
		|=> !o_network_fault_indicator)
		else $error("error LED lit with no error");

	link_idle_a: assert property (
		i_link_up && !i_link_traffic |=> o_link_activity_indicator)
		else $error("link LED not steady on idle link");

	link_busy_a: assert property (
		i_link_up && i_link_traffic
		|=> o_link_activity_indicator == $past(tb_flash))
		else $error("link LED not flashing on traffic");

	link_down_a: assert property (
		!i_link_up |=> !o_link_activity_indicator)
		else $error("link LED lit without link");

	slot_stable_a: assert property (
		!tb_tick |-> $stable(tb_flash) && $stable(tb_double))
		else $error("pattern changed between slot ticks");

	err_priority_a: assert property (
		i_fieldbus_variant && i_wdog_timeout && i_local_err
		&& !tb_single && tb_double |=> o_network_fault_indicator)
		else $error("local error shown over watchdog");

	err_local_cfg_a: assert property (
		i_fieldbus_variant && i_local_err && i_cfg_defect && !i_wdog_timeout
		&& !tb_single && tb_flash |=> !o_network_fault_indicator)
		else $error("configuration shown over local error");

	stage_on_a: assert property (
		!i_fault && !i_boot_fail |=> !o_stage_off)
		else $error("output stage off without fault");

	fault_dark_a: assert property (
		i_fault && !i_boot_fail && !tb_flash
		|=> !o_drive_state_indicator_red)
		else $error("fault red lit in dark slot");

	red_cause_a: assert property (
		!i_fault && !i_boot_fail |=> !o_drive_state_indicator_red)
		else $error("status red without fault or boot failure");

	drive_off_a: assert property (
		!i_drive_active && !i_fault && !i_boot_fail
		|=> !o_drive_state_indicator_green)
		else $error("status green while drive inactive");

	wait_dark_a: assert property (
		i_drive_active && !i_op_enabled && !i_fault && !i_boot_fail
		&& !tb_flash |=> !o_drive_state_indicator_green)
		else $error("waiting green lit in dark slot");

	one_color_a: assert property (
		!(o_drive_state_indicator_green && o_drive_state_indicator_red))
		else $error("status green and red together");

	code_idle_a: assert property (
		!i_boot_fail |=> !code_on)
		else $error("error code blinking without boot failure");

	run_serial_a: assert property (
		!i_fieldbus_variant |=> !o_network_run_indicator)
		else $error("network_run_indicator lit on serial variant");

	run_unconn_a: assert property (
		i_fieldbus_variant && i_net_state == NET_OP && !i_net_connected
		|=> !o_network_run_indicator)
		else $error("network_run_indicator lit without connection");

	run_bad_state_a: assert property (
		i_fieldbus_variant && !$onehot(i_net_state)
		|=> !o_network_run_indicator)
		else $error("network_run_indicator lit in unknown network state");

	run_safeop_dark_a: assert property (
		i_fieldbus_variant && i_net_state == NET_SAFEOP && !tb_single
		|=> !o_network_run_indicator)
		else $error("safe-operational network_run_indicator lit outside its slot");

	err_serial_a: assert property (
		!i_fieldbus_variant |=> !o_network_fault_indicator)
		else $error("error LED lit on serial variant");

	err_wdog_dark_a: assert property (
		i_fieldbus_variant && i_wdog_timeout && !tb_double
		|=> !o_network_fault_indicator)
		else $error("watchdog pattern lit in dark slot");

	err_cfg_dark_a: assert property (
		i_fieldbus_variant && i_cfg_defect && !i_local_err
		&& !i_wdog_timeout && !tb_flash |=> !o_network_fault_indicator)
		else $error("configuration pattern lit in dark slot");

	link_busy_dark_a: assert property (
		i_link_up && i_link_traffic && !tb_flash
		|=> !o_link_activity_indicator)
		else $error("link LED lit in dark slot on traffic");

	tick_pulse_a: assert property (
		tb_tick |=> !tb_tick)
		else $error("slot tick longer than one cycle");

	flash_toggle_a: assert property (
		tb_tick |-> tb_flash != $past(tb_flash))
		else $error("flash pattern did not toggle on tick");

	single_in_double_a: assert property (
		tb_single |-> tb_double && tb_flash)
		else $error("single flash slot not lit in other patterns");
endmodule

/* dsle_led_viewer.sv */
// Front-panel LED viewer: counts lit cycles per LED since the last clear.
// Assumes LED lines are synchronous to i_clk and sampled once per cycle.
`timescale 1ns/1ps
module dsle_led_viewer (
	input wire logic i_clk,
	input wire logic i_clear,
	input wire logic [5:0] i_led,
	output logic [5:0][7:0] o_lit
);
	// Duty over a frame is what the operator tells patterns apart by
	always_ff @(posedge i_clk) begin
		for (int i = 0; i < 6; i++) begin
			if (i_clear) begin
				o_lit[i] <= 8'h00;
			end else begin
				o_lit[i] <= o_lit[i] + {7'h00, i_led[i]};
			end
		end
	end
endmodule

/* test_dsle_led_encoder.sv */
// Self-checking bench for the drive drive_state_indicator encoder.
// Assumes a short slot length; every pattern repeats within one frame.
`timescale 1ns/1ps
module test_dsle_led_encoder import dsle_pkg::*;;
	localparam int TICK = 4;
	localparam int FRAME = TICK * 10;
	localparam logic [7:0] STEADY = 8'(FRAME);
	localparam logic [7:0] FLASH = 8'(FRAME / 2);
	localparam logic [7:0] SINGLE = 8'(TICK);
	localparam logic [7:0] DOUBLE = 8'(2 * TICK);
	// Code 3: three lit slots, two gaps, five dark: exactly one frame
	localparam logic [7:0] CODE3 = 8'(3 * TICK);
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic fb = 1'b1;
	logic [3:0] drv = 4'h0;
	logic [CODE_W-1:0] code = 4'h3;
	logic supply = 1'b1;
	logic [3:0] net = 4'h1;
	logic conn = 1'b0;
	logic [2:0] err = 3'h0;
	logic [1:0] lnk = 2'h1;
	logic clear = 1'b0;
	logic [5:0] led;
	logic stage_off;
	logic [5:0][7:0] lit;
	int err_total = 0;
	int total_checks = 0;

	always #10 clk = ~clk;

	dsle_led_encoder #(.TICK_CYCLES(TICK)) u_dsle_led_encoder (
		.i_clk(clk),
		.i_srst(srst),
		.i_fieldbus_variant(fb),
		.i_drive_active(drv[0]),
		.i_op_enabled(drv[1]),
		.i_fault(drv[2]),
		.i_boot_fail(drv[3]),
		.i_boot_code(code),
		.i_supply_ok(supply),
		.i_net_state(net),
		.i_net_connected(conn),
		.i_cfg_defect(err[0]),
		.i_local_err(err[1]),
		.i_wdog_timeout(err[2]),
		.i_link_up(lnk[0]),
		.i_link_traffic(lnk[1]),
		.o_drive_state_indicator_green(led[0]),
		.o_drive_state_indicator_red(led[1]),
		.o_stage_off(stage_off),
		.o_supply_ok_indicator(led[2]),
		.o_network_run_indicator(led[3]),
		.o_network_fault_indicator(led[4]),
		.o_link_activity_indicator(led[5])
	);

	dsle_led_viewer u_dsle_led_viewer (
		.i_clk(clk),
		.i_clear(clear),
		.i_led(led),
		.o_lit(lit)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp,
		input string msg);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s: seen %0d expected %0d", $time, msg,
				seen, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Let the new inputs land, then count one whole frame
	task automatic measure();
		repeat (3) @(posedge clk);
		clear <= 1'b1;
		@(posedge clk);
		clear <= 1'b0;
		repeat (FRAME) @(posedge clk);
		#1;
	endtask

	task automatic t_supply(input logic s, input logic [7:0] exp);
		@(posedge clk);
		supply <= s;
		measure();
		check(lit[2], exp, "supply indicator");
	endtask

	task automatic t_status(input logic [3:0] d, input logic [7:0] g,
		input logic [7:0] r, input logic so);
		@(posedge clk);
		drv <= d;
		measure();
		check(lit[0], g, "status green");
		check(lit[1], r, "status red");
		check({7'h00, stage_off}, {7'h00, so}, "stage off");
	endtask

	task automatic t_run(input logic f, input logic [3:0] n, input logic c,
		input logic [7:0] exp);
		@(posedge clk);
		fb <= f;
		net <= n;
		conn <= c;
		measure();
		check(lit[3], exp, "run indicator");
	endtask

	task automatic t_error(input logic f, input logic [2:0] e,
		input logic [7:0] exp);
		@(posedge clk);
		fb <= f;
		err <= e;
		measure();
		check(lit[4], exp, "fault indicator");
	endtask

	task automatic t_link(input logic f, input logic [1:0] l,
		input logic [7:0] exp);
		@(posedge clk);
		fb <= f;
		lnk <= l;
		measure();
		check(lit[5], exp, "link indicator");
	endtask

	initial begin
		#200000;
		err_total++;
		$display("[FAIL] %0t watchdog expired", $time);
		results();
	end

	initial begin
		repeat (4) @(posedge clk);
		#1;
		check({1'b0, stage_off, led}, 8'h00, "outputs in reset");
		@(posedge clk);
		srst <= 1'b0;
		t_supply(1'b1, STEADY);
		t_supply(1'b0, 8'h00);
		t_status(4'h3, STEADY, 8'h00, 1'b0);
		t_status(4'h1, FLASH, 8'h00, 1'b0);
		t_status(4'h7, 8'h00, FLASH, 1'b1);
		t_status(4'hf, 8'h00, CODE3, 1'b1);
		t_status(4'h2, 8'h00, 8'h00, 1'b0);
		t_run(1'b1, NET_OP, 1'b1, STEADY);
		t_run(1'b1, NET_OP, 1'b0, 8'h00);
		t_run(1'b1, NET_PREOP, 1'b1, FLASH);
		t_run(1'b1, NET_SAFEOP, 1'b1, SINGLE);
		t_run(1'b1, NET_INIT, 1'b1, 8'h00);
		t_run(1'b1, 4'h3, 1'b1, 8'h00);
		t_run(1'b0, NET_OP, 1'b1, 8'h00);
		t_error(1'b1, 3'h1, FLASH);
		t_error(1'b1, 3'h2, SINGLE);
		t_error(1'b1, 3'h4, DOUBLE);
		t_error(1'b1, 3'h0, 8'h00);
		t_error(1'b1, 3'h7, DOUBLE);
		t_error(1'b1, 3'h3, SINGLE);
		t_error(1'b0, 3'h7, 8'h00);
		t_link(1'b1, 2'h1, STEADY);
		t_link(1'b1, 2'h3, FLASH);
		t_link(1'b1, 2'h0, 8'h00);
		t_link(1'b1, 2'h2, 8'h00);
		t_link(1'b0, 2'h3, FLASH);
		results();
	end
endmodule
